// file: hw/amp_cfg.svh
// Constants for the amplifier control word and its two-wire slave.
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH
`define AMP_CTL_RESET      8'hCC
`define AMP_SPK_LSB        0
`define AMP_SPK_MSB        2
`define AMP_HP_LSB_BIT     3
`define AMP_HP_MSB_BIT     4
`define AMP_MONO_BIT       5
`define AMP_STEREO_BIT     6
`define AMP_RUN_BIT        7
`define AMP_DEV_ADDR       7'h4C
`define AMP_BIT_COUNT_LAST 4'h8
`define AMP_HP_DB_00       8'hFE
`define AMP_HP_DB_01       8'h01
`define AMP_HP_DB_10       8'h04
`define AMP_HP_DB_11       8'h07
`endif

// file: hw/amp_pkg.sv
// Types shared by the amplifier control word logic.
`default_nettype none
package amp_pkg;
	// ---------------------------------------------------------------
	// Input mode encoding.
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		AMP_MUTE   = 2'h0, // No input reaches any output.
		AMP_MONO   = 2'h1, // Mono input drives both outputs.
		AMP_STEREO = 2'h2, // Left and right to their outputs.
		AMP_MIX    = 2'h3  // Half of mono plus half of stereo.
	} amp_mode_t;

	// Decoded settings carried to the analog side.
	typedef struct packed {
		logic [7:0] speaker_db;   // Speaker gain in dB, unsigned.
		logic [7:0] headphone_db; // Headphone gain in dB, signed.
		amp_mode_t  mode;         // Selected input mode.
		logic       mix_halve;    // Attenuate inputs by 6 dB before sum.
		logic       amps_on;      // Drive amplifiers, bias, pump on.
		logic       hp_1k_load;   // Headphone outputs at 1 kilohm.
	} amp_settings_t;
endpackage : amp_pkg
`default_nettype wire

// file: hw/amp_decode.sv
// Decoder from control word to gain, mode and power settings.
`default_nettype none
`include "amp_cfg.svh"
module amp_decode (
	input  wire logic              [7:0] word,     // Stored control word.
	input  wire logic                    pin_n,    // Synced shutdown pin.
	output amp_pkg::amp_settings_t       settings  // Decoded settings.
);
	import amp_pkg::*;

	// ---------------------------------------------------------------
	// Combinational decode.
	// ---------------------------------------------------------------
	logic [2:0] speaker_gain_field; // Speaker code n.
	logic       run_bit;            // Soft run enable.
	logic       powered;            // Both enables present.

	assign speaker_gain_field = word[`AMP_SPK_MSB:`AMP_SPK_LSB];
	assign run_bit            = word[`AMP_RUN_BIT];
	// Either the pin or the soft bit alone forces shutdown.
	assign powered = run_bit & pin_n;

	// Gain is 3n dB; computed as 2n plus n to avoid a multiplier.
	always_comb begin
		settings = '0;
		settings.speaker_db = {4'h0, speaker_gain_field, 1'b0}
			+ {5'h00, speaker_gain_field};
		case ({word[`AMP_HP_MSB_BIT], word[`AMP_HP_LSB_BIT]})
			2'h0: settings.headphone_db = `AMP_HP_DB_00;
			2'h1: settings.headphone_db = `AMP_HP_DB_01;
			2'h2: settings.headphone_db = `AMP_HP_DB_10;
			default: settings.headphone_db = `AMP_HP_DB_11;
		endcase
		// Stereo bit is the high bit of the mode, mono the low one.
		settings.mode = amp_mode_t'({word[`AMP_STEREO_BIT],
			word[`AMP_MONO_BIT]});
		settings.mix_halve  = (settings.mode == AMP_MIX);
		settings.amps_on    = powered;
		settings.hp_1k_load = ~pin_n;
	end
endmodule : amp_decode
`default_nettype wire

// file: hw/amp_command_register.sv
// Two-wire write-only slave holding the amplifier control word.
// Behaviour
// - One control word sets gains, mode, shutdown.
// - Reset value sets bits 2,3,6,7 only.
// - Speaker gain is three dB per code.
// - Headphone codes give -2,+1,+4,+7 dB.
// - Bits 6..5 select mute, mono, stereo, mix.
// - Mix halves each input before summing.
// - Bit 7 zero means soft shutdown.
// - Pin low disables amps, headphone 1k.
// - Interface and word survive shutdown.
// - Start, address write, one byte, stop.
// - Never drive data for a read.
// - Stop recognised anywhere except in the start's clock pulse.
`default_nettype none
`include "amp_cfg.svh"
module amp_command_register (
	input  wire logic                    clk_sys,        // 50 MHz clock.
	input  wire logic                    nrst,           // Sync reset, low.
	input  wire logic                    scl_i,          // Bus clock pin.
	input  wire logic                    sda_i,          // Bus data pin.
	output logic                         sda_o,          // Data drive level.
	output logic                         sda_oe_n,       // Low pulls line.
	input  wire logic                    power_down_pin_n, // Shutdown pin.
	output logic                   [7:0] amp_control_word, // Stored word.
	output amp_pkg::amp_settings_t       settings        // Decoded outputs.
);
	import amp_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers.
	// ---------------------------------------------------------------
	logic [1:0] scl_sync;  // Two-stage sync of bus clock.
	logic [1:0] sda_sync;  // Two-stage sync of bus data.
	logic [1:0] pin_sync;  // Two-stage sync of shutdown pin.
	logic       scl_d;     // Previous synced clock.
	logic       sda_d;     // Previous synced data.

	// Only stage one feeds stage two; logic reads stage two only.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			pin_sync <= 2'h0;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			pin_sync <= {pin_sync[0], power_down_pin_n};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end

	// ---------------------------------------------------------------
	// Bus event detection.
	// ---------------------------------------------------------------
	logic scl_rise;   // Clock rising: sample data.
	logic scl_fall;   // Clock falling: change drive.
	logic start_seen; // Data falls while clock high.
	logic stop_seen;  // Data rises while clock high.
	logic start_in_pulse; // A start occurred in this high pulse.

	assign scl_rise   = scl_sync[1] & ~scl_d;
	assign scl_fall   = ~scl_sync[1] & scl_d;
	assign start_seen = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign stop_seen  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	// Remember a start until the clock goes low again.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			start_in_pulse <= 1'b0;
		end else if (start_seen) begin
			start_in_pulse <= 1'b1;
		end else if (!scl_sync[1]) begin
			start_in_pulse <= 1'b0;
		end
	end

	logic stop_valid; // Stop honoured unless same pulse as start.
	assign stop_valid = stop_seen & ~start_in_pulse;

	// ---------------------------------------------------------------
	// Transfer state machine.
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, // Waiting for a start.
		ST_ADDR = 3'h1, // Shifting in the address byte.
		ST_AACK = 3'h2, // Acknowledge slot after address.
		ST_DATA = 3'h3, // Shifting in the data byte.
		ST_DACK = 3'h4, // Acknowledge slot after data.
		ST_DONE = 3'h5  // Ignore further bits until stop.
	} amp_state_t;

	amp_state_t state;       // Current transfer phase.
	logic [3:0] bit_cnt;     // Bits shifted in this byte.
	logic [7:0] shifter;     // Incoming byte.
	logic       ack_drive;   // Pull data low for the ninth bit.
	logic       byte_full;   // Eighth bit has just been sampled.
	logic [7:0] next_byte;   // Byte including the newest bit.

	assign next_byte = {shifter[6:0], sda_sync[1]};
	assign byte_full = scl_rise & (bit_cnt == (`AMP_BIT_COUNT_LAST - 4'h1));

	// Bits are sampled on clock rise; state moves on falls so the
	// acknowledge drive spans the whole ninth clock pulse.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			state   <= ST_IDLE;
			bit_cnt <= 4'h0;
			shifter <= 8'h00;
		end else if (start_seen) begin
			state   <= ST_ADDR;
			bit_cnt <= 4'h0;
		end else if (stop_valid) begin
			state   <= ST_IDLE;
			bit_cnt <= 4'h0;
		end else begin
			case (state)
				ST_ADDR, ST_DATA: begin
					if (scl_rise) begin
						shifter <= next_byte;
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == `AMP_BIT_COUNT_LAST) begin
						bit_cnt <= 4'h0;
						state   <= (state == ST_ADDR) ? ST_AACK : ST_DACK;
					end
				end
				// Only a write to this slave goes on to a data byte; any
				// other address or a read waits quietly for the stop, so
				// the line is never pulled while a master reads.
				ST_AACK: begin
					if (scl_fall) begin
						state <= (shifter[7:1] == `AMP_DEV_ADDR
							&& !shifter[0]) ? ST_DATA : ST_DONE;
					end
				end
				ST_DACK: begin
					if (scl_fall) begin
						state <= ST_DONE;
					end
				end
				ST_IDLE, ST_DONE: begin
					bit_cnt <= 4'h0;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Acknowledge and data drive.
	// ---------------------------------------------------------------
	logic addr_match; // Address byte names this slave.
	assign addr_match = (shifter[7:1] == `AMP_DEV_ADDR);

	// The device acknowledges its address with either direction bit,
	// but only pulls the line in acknowledge slots, never for data.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ack_drive <= 1'b0;
		end else if (start_seen || stop_valid) begin
			ack_drive <= 1'b0;
		end else if (scl_fall && bit_cnt == `AMP_BIT_COUNT_LAST) begin
			if (state == ST_ADDR) begin
				ack_drive <= addr_match;
			end else if (state == ST_DATA) begin
				ack_drive <= 1'b1;
			end
		end else if (scl_fall) begin
			ack_drive <= 1'b0;
		end
	end

	assign sda_o    = 1'b0;
	assign sda_oe_n = ~ack_drive;

	// Data phase is honoured only after a write to this slave.
	logic write_sel; // Address matched with direction zero.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			write_sel <= 1'b0;
		end else if (start_seen) begin
			write_sel <= 1'b0;
		end else if (state == ST_AACK && scl_fall) begin
			write_sel <= addr_match & ~shifter[0];
		end
	end

	// ---------------------------------------------------------------
	// Control word storage.
	// ---------------------------------------------------------------
	logic [7:0] data_hold; // Received data awaiting its ack slot.

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			data_hold <= 8'h00;
		end else if (state == ST_DATA && byte_full) begin
			data_hold <= next_byte;
		end
	end

	// Commit at the end of the acknowledge pulse so a partial byte
	// cut short by a stop never reaches the gains; shutdown does
	// not gate this path, so writes land even when powered down.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			amp_control_word <= `AMP_CTL_RESET;
		end else if (state == ST_DACK && scl_fall && write_sel) begin
			amp_control_word <= data_hold;
		end
	end

	amp_decode u_decode (
		.word     (amp_control_word),
		.pin_n    (pin_sync[1]),
		.settings (settings)
	);

	// ---------------------------------------------------------------
	// Checks.
	// ---------------------------------------------------------------
	sequence ack_slot_s;
		state == ST_DACK && scl_fall && write_sel;
	endsequence

	word_commit_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		ack_slot_s |=> amp_control_word == $past(data_hold))
		else $error("word not committed after ack");
	word_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!(state == ST_DACK && scl_fall) |=> $stable(amp_control_word))
		else $error("word changed outside ack");
	reset_value_a: assert property (@(posedge clk_sys)
		!nrst |=> amp_control_word == 8'hCC)
		else $error("bad reset value");
	spk_gain_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		settings.speaker_db == 8'(3 * amp_control_word[2:0]))
		else $error("speaker gain wrong");
	hp_gain_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		amp_control_word[4:3] == 2'h0 |-> settings.headphone_db == 8'hFE)
		else $error("headphone gain wrong");
	mix_mode_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		settings.mix_halve == (amp_control_word[6:5] == 2'h3))
		else $error("mix attenuation wrong");
	soft_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!amp_control_word[7] |-> !settings.amps_on)
		else $error("soft shutdown ignored");
	pin_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!pin_sync[1] |-> !settings.amps_on && settings.hp_1k_load)
		else $error("pin shutdown ignored");
	no_read_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		state == ST_DONE || state == ST_IDLE |-> sda_oe_n)
		else $error("line driven outside ack");
	stop_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		stop_valid && !start_seen |=> state == ST_IDLE)
		else $error("stop not honoured");
endmodule : amp_command_register
`default_nettype wire

// file: bench/amp_bus_master.sv
// Two-wire bus master model that configures the amplifier slave.
`default_nettype none
module amp_bus_master (
	input  wire logic clk_sys,  // System clock, paces every bus phase.
	input  wire logic sda_line, // Resolved data wire with pull-up.
	output logic      scl,      // Bus clock, idle high.
	output logic      sda_rel   // One releases the data wire, zero pulls.
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// Bus phases.
	// ---------------------------------------------------------------
	// Phases of five system clocks run the bus near 4 MHz, far above 400 kHz.
	localparam int HALF = 5;
	// The bus idles high before the first frame.
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : ticks
	// Data falls while the clock is high; also serves as repeated start.
	task automatic start_cond();
		sda_rel <= 1'b1;
		ticks(HALF);
		scl <= 1'b1;
		ticks(HALF);
		sda_rel <= 1'b0;
		ticks(HALF);
		scl <= 1'b0;
	endtask : start_cond
	// Data moves two clocks after the clock falls so no false start shows.
	task automatic bit_xfer(input logic b, output logic seen);
		ticks(2);
		sda_rel <= b;
		ticks(HALF);
		scl <= 1'b1;
		ticks(HALF);
		seen = sda_line;
		scl <= 1'b0;
	endtask : bit_xfer
	// Data rises while the clock is high, at any point of a frame.
	task automatic stop_cond();
		ticks(2);
		sda_rel <= 1'b0;
		ticks(HALF);
		scl <= 1'b1;
		ticks(HALF);
		sda_rel <= 1'b1;
		ticks(HALF);
	endtask : stop_cond
	// Eight bits, most significant first, then the ninth clock released.
	task automatic xfer_byte(input logic [7:0] b, output logic [7:0] got,
			output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], s);
			got[i] = s;
		end
		bit_xfer(1'b1, ack);
	endtask : xfer_byte
endmodule : amp_bus_master
`default_nettype wire

// file: bench/amp_command_register_tb_top.sv
// Self-checking bench for the amplifier control word slave.
`default_nettype none
`include "amp_cfg.svh"
`define AMP_CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
	err_total++; $display("mismatch %s exp %h got %h", nm, exp, got); end end
module amp_command_register_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import amp_pkg::*;
	logic clk_sys;                 // 50 MHz clock.
	logic nrst;                    // Synchronous reset, active low.
	logic scl;                     // Bus clock from the master.
	logic sda_rel;                 // Master data release.
	logic power_down_pin_n;        // Hardware shutdown pin.
	wire logic sda_o;              // Slave drive level.
	wire logic sda_oe_n;           // Slave pulls while low.
	wire logic sda_line;           // Resolved open-drain wire.
	wire logic [7:0] word;         // Stored control word.
	amp_settings_t settings;       // Decoded settings.
	int err_total = 0;             // Mismatches seen.
	int checks = 0;                // Comparisons made.
	logic [7:0] hp_db [4] = '{8'hFE, 8'h01, 8'h04, 8'h07}; // Headphone dB.
	// Pull-up wins unless someone pulls the wire low.
	assign sda_line = sda_rel & (sda_oe_n | sda_o);
	amp_bus_master i_m (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
		.sda_rel(sda_rel));
	amp_command_register i_dut (.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
		.power_down_pin_n(power_down_pin_n), .amp_control_word(word),
		.settings(settings));
	// ---------------------------------------------------------------
	// Clock, watchdog and verdict.
	// ---------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	// The tests need about 3500 clocks, so this limit only catches hangs.
	initial begin
		repeat (30000) @(posedge clk_sys);
		err_total++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// ---------------------------------------------------------------
	// Access tasks.
	// ---------------------------------------------------------------
	// One whole frame: start, address with write, one byte, stop.
	task automatic write_word(input logic [6:0] a, input logic [7:0] d,
			output logic [1:0] ack);
		logic [7:0] g;
		i_m.start_cond();
		i_m.xfer_byte({a, 1'b0}, g, ack[1]);
		i_m.xfer_byte(d, g, ack[0]);
		i_m.stop_cond();
	endtask : write_word
	// Every decoded field is worked out from the expected word and the shutdown pin.
	task automatic check_word(input logic [7:0] w);
		`AMP_CHK("word", w, word)
		`AMP_CHK("speaker_db", 8'(3 * w[2:0]), settings.speaker_db)
		`AMP_CHK("headphone_db", hp_db[w[4:3]], settings.headphone_db)
		`AMP_CHK("mode", w[6:5], settings.mode)
		`AMP_CHK("mix_halve", w[6:5] == 2'h3, settings.mix_halve)
		`AMP_CHK("amps_on", w[7] & power_down_pin_n, settings.amps_on)
		`AMP_CHK("hp_1k_load", ~power_down_pin_n, settings.hp_1k_load)
	endtask : check_word
	// ---------------------------------------------------------------
	// Tests.
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] g;
		logic [1:0] ack;
		logic a;
		logic s;
		nrst <= 1'b0;
		power_down_pin_n <= 1'b1;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		// Let the pin and bus synchronisers fill before looking.
		repeat (6) @(posedge clk_sys);
		check_word(8'hCC);
		$display("test reset done");
		// Every gain code and every input mode, back to back.
		for (int i = 0; i < 8; i++) begin
			d = {1'b1, 2'(i), 2'(i), 3'(i)};
			write_word(`AMP_DEV_ADDR, d, ack);
			`AMP_CHK("ack", 2'b00, ack)
			check_word(d);
		end
		$display("test codes done");
		// Soft shutdown, then the pin, with a write stored meanwhile.
		write_word(`AMP_DEV_ADDR, 8'h4B, ack);
		check_word(8'h4B);
		power_down_pin_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check_word(8'h4B);
		write_word(`AMP_DEV_ADDR, 8'hD5, ack);
		`AMP_CHK("ack", 2'b00, ack)
		check_word(8'hD5);
		power_down_pin_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check_word(8'hD5);
		$display("test shutdown done");
		// Another address is ignored; a read is acked but reads ones,
		// and the slave leaves the ninth clock of the read alone too.
		write_word(`AMP_DEV_ADDR ^ 7'h01, 8'h00, ack);
		`AMP_CHK("ack", 2'b11, ack)
		i_m.start_cond();
		i_m.xfer_byte({`AMP_DEV_ADDR, 1'b1}, g, a);
		`AMP_CHK("ack", 1'b0, a)
		i_m.xfer_byte(8'hFF, g, a);
		`AMP_CHK("read", 8'hFF, g)
		`AMP_CHK("read_ack", 1'b1, a)
		i_m.stop_cond();
		check_word(8'hD5);
		$display("test refused done");
		// A stop halfway through the data byte leaves the word alone.
		i_m.start_cond();
		i_m.xfer_byte({`AMP_DEV_ADDR, 1'b0}, g, a);
		for (int i = 0; i < 4; i++) begin
			i_m.bit_xfer(1'b0, s);
		end
		i_m.stop_cond();
		check_word(8'hD5);
		write_word(`AMP_DEV_ADDR, 8'hE2, ack);
		check_word(8'hE2);
		$display("test abort done");
		tally_and_finish();
	end
endmodule : amp_command_register_tb_top
`default_nettype wire
